// ---- logic/qdac_pkg.sv ----
// What this block does
// - Serial bits collect in a 32-bit shift register; a frame is 32 bits.
// - Frame: four ignored bits, command, channel, then data; MSB first.
// - Data field is the code, then ignored padding bits filling the frame.
// - Frame select falling starts a write; bits sampled on shift clock falls.
// - In standalone mode the 32nd falling edge captures the last bit and executes the command.
// - After the 32nd edge frame select may stay low or rise.
// - Frame select rising before the 32nd edge discards the frame.
// - Commands 0-3: write input, update, write and update all, write+update.
// - Commands 4-7: power mode, clear code, load override, software reset.
// - Command 8 writes chain enable; codes 9 to 15 do nothing.
// - Channel values 0-3 select A-D; value 15 selects all four.
// - Converter code is straight unsigned binary.
// - Top four code bits become 15 thermometer lines; low 12 go to ladder.
// - Chain mode set by bit 1 of chain enable; reset is standalone.
// - In chain mode old bits leave on chain out at rising shift clock.
// - Chained frames are 32N clocks; any other count is discarded.
// - While frame select is high clock and data are ignored.
// - Load low updates at execution; a later low pulse copies all inputs.
// - A channel with override bit set updates as if load were low.
// - Clear asserted during a frame aborts it with nothing executed.
package qdac_pkg;
  localparam int FRAME_BITS = 32;
  localparam int CODE_W = 16;
  localparam int NUM_CH = 4;
  localparam int CNT_W = 5;
  localparam logic [4:0] LAST_BIT = 5'h1F;
  // Field positions in the received word
  localparam int CMD_MSB = 27;
  localparam int CMD_LSB = 24;
  localparam int ADDR_MSB = 23;
  localparam int ADDR_LSB = 20;
  localparam int CODE_MSB = 19;
  localparam int CODE_LSB = 4;
  localparam int PD_MSB = 9;
  localparam int PD_LSB = 8;
  localparam int CHAIN_BIT = 1;
  // Commands
  localparam logic [3:0] CMD_WRITE_IN = 4'h0;
  localparam logic [3:0] CMD_UPDATE = 4'h1;
  localparam logic [3:0] CMD_WRITE_ALL = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
  localparam logic [3:0] CMD_POWER = 4'h4;
  localparam logic [3:0] CMD_CLEAR_CODE = 4'h5;
  localparam logic [3:0] CMD_OVERRIDE = 4'h6;
  localparam logic [3:0] CMD_SOFT_RESET = 4'h7;
  localparam logic [3:0] CMD_CHAIN = 4'h8;
  localparam logic [3:0] ADDR_ALL = 4'hF;
  // Clear code selections and values
  localparam logic [1:0] CLR_NOP = 2'h3;
  localparam logic [15:0] CLR_ZERO = 16'h0000;
  localparam logic [15:0] CLR_MID = 16'h8000;
  localparam logic [15:0] CLR_FULL = 16'hFFFF;
  // Reset values
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [1:0] CHAIN_RST = 2'h0;
  localparam logic [1:0] CLR_SEL_RST = 2'h0;
  localparam logic [3:0] OVR_RST = 4'h0;
  localparam logic [7:0] PD_RST = 8'h00;
  // Synchroniser order {clear, load, data, clock, select}, idle levels
  localparam logic [4:0] PIN_RST = 5'h1B;
  localparam int P_SEL = 0;
  localparam int P_CLK = 1;
  localparam int P_DAT = 2;
  localparam int P_LD = 3;
  localparam int P_CLR = 4;
  typedef enum logic [2:0] {
    QDAC_IDLE = 3'b001,
    QDAC_SHIFT = 3'b010,
    QDAC_HOLD = 3'b100
  } qdac_state_type;
endpackage : qdac_pkg

// ---- logic/qdac_port.sv ----
`timescale 1ns/1ps
module qdac_port (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic frame_sync_n_i,
  input wire logic shift_clk_i,
  input wire logic serial_data_i,
  input wire logic load_outputs_n_i,
  input wire logic async_clear_n_i,
  output logic [63:0] dac_code_o,
  output logic [63:0] input_code_o,
  output logic [59:0] thermometer_switches_o,
  output logic [47:0] ladder_switches_o,
  output logic [7:0] power_mode_o,
  output logic [3:0] load_override_o,
  output logic [1:0] clear_code_o,
  output logic chain_enable_o,
  output logic chain_out_o
);

  // Synchroniser stages and their delayed copy
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] pin_prev;

  // Frame sequencer state and received word
  qdac_pkg::qdac_state_type state;
  logic [31:0] shift_reg;
  logic [4:0] bit_cnt;
  logic full_seen;
  logic exec_q;
  logic [31:0] word_q;

  // Command registers; only bit 1 of chain enable has any effect
  logic [1:0] chain_enable_register;
  logic [1:0] clear_sel;
  logic [3:0] override;
  logic [7:0] pd_mode;
  logic chain_out;

  // Per channel storage, input side and converter side
  logic [15:0] in_reg [4];
  logic [15:0] dac_reg [4];

  // Pins are asynchronous to mclk; two flops before anything looks
  // Detection lags each pin by about three mclk periods, so every shift
  // clock phase must last at least four periods; 50 MHz is out of reach
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= qdac_pkg::PIN_RST;
      pin_sync <= qdac_pkg::PIN_RST;
      pin_prev <= qdac_pkg::PIN_RST;
    end else begin
      pin_meta <= {async_clear_n_i, load_outputs_n_i, serial_data_i,
                   shift_clk_i, frame_sync_n_i};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Edge events, all from the second and third stage
  // Reset values match the idle pin levels, so no false edge follows
  // Load acts on its level during execution and on its falling edge
  logic sel_low;
  logic sel_fall;
  logic sel_rise;
  logic clk_fall;
  logic clk_rise;
  logic din;
  logic ld_low;
  logic ld_fall;
  logic clr_fall;
  logic chain_mode;
  assign sel_low = ~pin_sync[qdac_pkg::P_SEL];
  assign sel_fall = pin_prev[qdac_pkg::P_SEL] & ~pin_sync[qdac_pkg::P_SEL];
  assign sel_rise = ~pin_prev[qdac_pkg::P_SEL] & pin_sync[qdac_pkg::P_SEL];
  assign clk_fall = pin_prev[qdac_pkg::P_CLK] & ~pin_sync[qdac_pkg::P_CLK];
  assign clk_rise = ~pin_prev[qdac_pkg::P_CLK] & pin_sync[qdac_pkg::P_CLK];
  assign din = pin_sync[qdac_pkg::P_DAT];
  assign ld_low = ~pin_sync[qdac_pkg::P_LD];
  assign ld_fall = pin_prev[qdac_pkg::P_LD] & ~pin_sync[qdac_pkg::P_LD];
  assign clr_fall = pin_prev[qdac_pkg::P_CLR] & ~pin_sync[qdac_pkg::P_CLR];
  assign chain_mode = chain_enable_register[qdac_pkg::CHAIN_BIT];

  // Frame sequencing: start, count, finish, abort
  // Standalone frames execute on the 32nd fall; chained ones wait for the
  // select rise, as only then is the whole 32N count known
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= qdac_pkg::QDAC_IDLE;
      shift_reg <= 32'h0000_0000;
      bit_cnt <= 5'h00;
      full_seen <= 1'b0;
      exec_q <= 1'b0;
      word_q <= 32'h0000_0000;
    end else begin
      exec_q <= 1'b0;
      case (state)
        qdac_pkg::QDAC_IDLE: begin
          // Clock and data ignored while select is high
          if (sel_fall && !clr_fall) begin
            bit_cnt <= 5'h00;
            full_seen <= 1'b0;
            state <= qdac_pkg::QDAC_SHIFT;
          end
        end
        qdac_pkg::QDAC_SHIFT: begin
          if (clr_fall) begin
            state <= qdac_pkg::QDAC_IDLE;
          end else if (sel_rise) begin
            // Chained frame ends on select rise; only whole words count
            if (chain_mode && full_seen &&
                bit_cnt == 5'h00) begin
              exec_q <= 1'b1;
              word_q <= shift_reg;
            end
            state <= qdac_pkg::QDAC_IDLE;
          end else if (clk_fall) begin
            shift_reg <= {shift_reg[30:0], din};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == qdac_pkg::LAST_BIT) begin
              full_seen <= 1'b1;
              if (!chain_mode) begin
                exec_q <= 1'b1;
                word_q <= {shift_reg[30:0], din};
                state <= qdac_pkg::QDAC_HOLD;
              end
            end
          end
        end
        qdac_pkg::QDAC_HOLD: begin
          // Extra clocks dropped; select may stay low or rise
          if (sel_rise || clr_fall) begin
            state <= qdac_pkg::QDAC_IDLE;
          end
        end
        default: begin
          state <= qdac_pkg::QDAC_IDLE;
        end
      endcase
    end
  end

  // Bits past the shift register leave on the rising shift clock
  // Shown on the rise so the next device in line samples it on the fall
  // after, giving it half a shift clock of setup
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      chain_out <= 1'b0;
    end else if (!chain_mode) begin
      chain_out <= 1'b0;
    end else if (state == qdac_pkg::QDAC_SHIFT && clk_rise) begin
      chain_out <= shift_reg[31];
    end
  end

  // Decoded fields of the executed word
  // Addresses other than 0 to 3 and 15 select no channel at all
  logic [3:0] cmd;
  logic [3:0] addr;
  logic [15:0] code;
  logic [3:0] ch_sel;
  logic [15:0] clr_value;
  assign cmd = word_q[qdac_pkg::CMD_MSB:qdac_pkg::CMD_LSB];
  assign addr = word_q[qdac_pkg::ADDR_MSB:qdac_pkg::ADDR_LSB];
  assign code = word_q[qdac_pkg::CODE_MSB:qdac_pkg::CODE_LSB];
  always_comb begin
    ch_sel = 4'h0;
    clr_value = qdac_pkg::CLR_ZERO;
    if (addr == qdac_pkg::ADDR_ALL) begin
      ch_sel = 4'hF;
    end else if (addr < 4'h4) begin
      ch_sel = 4'h1 << addr[1:0];
    end
    case (clear_sel)
      2'h1: clr_value = qdac_pkg::CLR_MID;
      2'h2: clr_value = qdac_pkg::CLR_FULL;
      default: clr_value = qdac_pkg::CLR_ZERO;
    endcase
  end

  // Control registers written by commands 4 to 8
  // A software reset also drops chain mode, back to the standalone default
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      chain_enable_register <= qdac_pkg::CHAIN_RST;
      clear_sel <= qdac_pkg::CLR_SEL_RST;
      override <= qdac_pkg::OVR_RST;
      pd_mode <= qdac_pkg::PD_RST;
    end else if (exec_q) begin
      case (cmd)
        qdac_pkg::CMD_POWER: begin
          for (int c = 0; c < qdac_pkg::NUM_CH; c++) begin
            if (word_q[c]) begin
              pd_mode[2*c +: 2] <= word_q[qdac_pkg::PD_MSB:qdac_pkg::PD_LSB];
            end
          end
        end
        qdac_pkg::CMD_CLEAR_CODE: clear_sel <= word_q[1:0];
        qdac_pkg::CMD_OVERRIDE: override <= word_q[3:0];
        qdac_pkg::CMD_SOFT_RESET: begin
          chain_enable_register <= qdac_pkg::CHAIN_RST;
          clear_sel <= qdac_pkg::CLR_SEL_RST;
          override <= qdac_pkg::OVR_RST;
          pd_mode <= qdac_pkg::PD_RST;
        end
        qdac_pkg::CMD_CHAIN: chain_enable_register <= word_q[1:0];
        default: begin
          // Data commands and reserved codes leave these alone
        end
      endcase
    end
  end

  // Per channel input and converter registers plus switch decode
  for (genvar ch = 0; ch < qdac_pkg::NUM_CH; ch++) begin : g_ch
    logic load_eff;
    logic [15:0] therm_in;
    // Override makes a channel behave as if its load pin were held low
    assign load_eff = ld_low | override[ch];

    // Priority: clear, then command, then a load fall; a load fall that
    // meets an executing command in the same cycle is lost
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        in_reg[ch] <= qdac_pkg::CODE_RST;
        dac_reg[ch] <= qdac_pkg::CODE_RST;
      end else if (clr_fall && clear_sel != qdac_pkg::CLR_NOP) begin
        // Clear takes priority over a same-cycle execution
        in_reg[ch] <= clr_value;
        dac_reg[ch] <= clr_value;
      end else if (exec_q) begin
        case (cmd)
          qdac_pkg::CMD_WRITE_IN: begin
            if (ch_sel[ch]) begin
              in_reg[ch] <= code;
              if (load_eff) begin
                dac_reg[ch] <= code;
              end
            end
          end
          qdac_pkg::CMD_UPDATE: begin
            if (ch_sel[ch]) begin
              dac_reg[ch] <= in_reg[ch];
            end
          end
          qdac_pkg::CMD_WRITE_ALL: begin
            if (ch_sel[ch]) begin
              in_reg[ch] <= code;
              dac_reg[ch] <= code;
            end else begin
              dac_reg[ch] <= in_reg[ch];
            end
          end
          qdac_pkg::CMD_WRITE_UPD: begin
            if (ch_sel[ch]) begin
              in_reg[ch] <= code;
              dac_reg[ch] <= code;
            end
          end
          qdac_pkg::CMD_SOFT_RESET: begin
            in_reg[ch] <= qdac_pkg::CODE_RST;
            dac_reg[ch] <= qdac_pkg::CODE_RST;
          end
          default: begin
            // Reserved and control commands other than soft reset touch no code
          end
        endcase
      end else if (ld_fall) begin
        dac_reg[ch] <= in_reg[ch];
      end
    end

    // Thermometer line k is high when the top nibble is at least k
    for (genvar k = 1; k < 16; k++) begin : g_therm
      assign therm_in[k] = (dac_reg[ch][15:12] >= 4'(k));
    end
    assign therm_in[0] = 1'b0;

    // Outputs registered so the switch lines change together
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        dac_code_o[16*ch +: 16] <= qdac_pkg::CODE_RST;
        input_code_o[16*ch +: 16] <= qdac_pkg::CODE_RST;
        thermometer_switches_o[15*ch +: 15] <= 15'h0000;
        ladder_switches_o[12*ch +: 12] <= 12'h000;
      end else begin
        dac_code_o[16*ch +: 16] <= dac_reg[ch];
        input_code_o[16*ch +: 16] <= in_reg[ch];
        thermometer_switches_o[15*ch +: 15] <= therm_in[15:1];
        ladder_switches_o[12*ch +: 12] <= dac_reg[ch][11:0];
      end
    end
  end

  // Status outputs straight from their registers
  assign power_mode_o = pd_mode;
  assign load_override_o = override;
  assign clear_code_o = clear_sel;
  assign chain_enable_o = chain_mode;
  assign chain_out_o = chain_out;

endmodule : qdac_port

// ---- tb/qdac_port_props.sv ----
`timescale 1ns/1ps
module qdac_port_props (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic frame_sync_n_i,
  input wire logic shift_clk_i,
  input wire logic serial_data_i,
  input wire logic load_outputs_n_i,
  input wire logic async_clear_n_i,
  input wire logic [63:0] dac_code_o,
  input wire logic [63:0] input_code_o,
  input wire logic [59:0] thermometer_switches_o,
  input wire logic [47:0] ladder_switches_o,
  input wire logic [7:0] power_mode_o,
  input wire logic [3:0] load_override_o,
  input wire logic [1:0] clear_code_o,
  input wire logic chain_enable_o,
  input wire logic chain_out_o
);
  logic [59:0] th_exp;
  logic [47:0] lad_exp;
  logic quiet;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Switch patterns implied by the codes now shown
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      lad_exp[c*12 +: 12] = dac_code_o[c*16 +: 12];
      for (int k = 1; k <= 15; k++) begin
        th_exp[c*15+k-1] = (dac_code_o[c*16+12 +: 4] >= 4'(k));
      end
    end
  end
  // Select, load and clear pins idle, so nothing may reach the registers
  assign quiet = frame_sync_n_i && load_outputs_n_i && async_clear_n_i;
  a_therm_decode: assert property (thermometer_switches_o == th_exp)
    else $error("thermometer lines disagree with code");
  a_ladder_bits: assert property (ladder_switches_o == lad_exp)
    else $error("ladder lines disagree with code");
  a_idle_quiet: assert property (
    quiet [*8] ##1 quiet |-> $stable(input_code_o))
    else $error("input codes moved while idle");
  a_load_copy: assert property (
    $fell(load_outputs_n_i) && frame_sync_n_i
    |-> ##[2:8] dac_code_o == input_code_o)
    else $error("load pulse did not copy input codes");
  a_clear_mid: assert property (
    $fell(async_clear_n_i) && clear_code_o == 2'h1
    |-> ##[2:8] dac_code_o == {4{16'h8000}})
    else $error("clear did not set midscale");
  a_chain_idle: assert property (
    (!chain_enable_o) [*2] |-> !chain_out_o)
    else $error("chain data seen in standalone mode");
  a_reset_zero: assert property ($fell(rst_i) |-> dac_code_o == '0
    && !chain_enable_o && power_mode_o == '0)
    else $error("registers not at reset value");
  // Each converter lane only ever takes its own input lane
  for (genvar g = 0; g < 4; g++) begin : g_lane
    a_dac_lane: assert property ($changed(dac_code_o[g*16 +: 16])
      |-> dac_code_o[g*16 +: 16] == input_code_o[g*16 +: 16])
      else $error("converter lane differs from input lane");
  end
  c_chain_on: cover property ($rose(chain_enable_o));
  c_load_pulse: cover property ($fell(load_outputs_n_i) && frame_sync_n_i);
  c_clear_pulse: cover property ($fell(async_clear_n_i));
endmodule : qdac_port_props

bind qdac_port qdac_port_props i_qdac_port_props (.mclk_i, .rst_i,
  .frame_sync_n_i, .shift_clk_i, .serial_data_i, .load_outputs_n_i,
  .async_clear_n_i, .dac_code_o, .input_code_o, .thermometer_switches_o,
  .ladder_switches_o, .power_mode_o, .load_override_o, .clear_code_o,
  .chain_enable_o, .chain_out_o);

// ---- tb/qdac_host.sv ----
`timescale 1ns/1ps
module qdac_host (
  output logic frame_sync_n_o,
  output logic shift_clk_o,
  output logic serial_data_o,
  input wire logic chain_in_i
);
  logic [63:0] rx;
  // Clock idles high and stands still between frames
  initial begin
    frame_sync_n_o = 1'b1;
    shift_clk_o = 1'b1;
    serial_data_o = 1'b0;
    rx = '0;
  end
  // Gated burst of n clocks at 6.25 MHz, below the 15.625 MHz that four-period phases allow
  task automatic send(input logic [63:0] w, input int n);
    frame_sync_n_o = 1'b0;
    #80;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_o = w[i];
      #80 shift_clk_o = 1'b0;
      rx = {rx[62:0], chain_in_i};
      #80 shift_clk_o = 1'b1;
    end
    #80 frame_sync_n_o = 1'b1;
    serial_data_o = ~serial_data_o; // Released line shows no stale bit
    #3000;
  endtask : send
endmodule : qdac_host

// ---- tb/qdac_port_tb.sv ----
`timescale 1ns/1ps
module qdac_port_tb;
  logic mclk_i;
  logic rst_i;
  logic ld_n;
  logic clr_n;
  logic fs_n;
  logic sck;
  logic sd;
  logic [63:0] dac;
  logic [63:0] inp;
  logic [59:0] th;
  logic [47:0] lad;
  logic [7:0] pm;
  logic [3:0] ovr;
  logic [1:0] cc;
  logic ce;
  logic co;
  int err_count;
  int checked;
  qdac_host i_qdac_host (.frame_sync_n_o(fs_n), .shift_clk_o(sck),
    .serial_data_o(sd), .chain_in_i(co));
  qdac_port i_qdac_port (.mclk_i(mclk_i), .rst_i(rst_i),
    .frame_sync_n_i(fs_n), .shift_clk_i(sck), .serial_data_i(sd),
    .load_outputs_n_i(ld_n), .async_clear_n_i(clr_n), .dac_code_o(dac),
    .input_code_o(inp), .thermometer_switches_o(th),
    .ladder_switches_o(lad), .power_mode_o(pm), .load_override_o(ovr),
    .clear_code_o(cc), .chain_enable_o(ce), .chain_out_o(co));
  task automatic chk(input string nm, input logic [63:0] got,
    input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One 32-bit frame: command, channel, 20-bit payload
  task automatic wr(input logic [3:0] c, input logic [3:0] a,
    input logic [19:0] d);
    i_qdac_host.send({36'h0, c, a, d}, 32);
  endtask : wr
  // Short low pulse on load or clear, then settle time
  task automatic pulse(input bit clr);
    @(negedge mclk_i);
    {ld_n, clr_n} = clr ? 2'b10 : 2'b01;
    repeat (4) @(negedge mclk_i);
    {ld_n, clr_n} = 2'b11;
    repeat (12) @(negedge mclk_i);
  endtask : pulse
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  // Whole run needs about 220 us
  initial begin
    #600000;
    err_count++;
    report_and_stop();
  end
  initial begin
    rst_i = 1'b1;
    ld_n = 1'b1;
    clr_n = 1'b1;
    err_count = 0;
    checked = 0;
    repeat (8) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    chk("idle regs", {ce, co, cc, ovr, pm}, 64'h0);
    chk("idle code", dac, 64'h0);
    wr(4'h3, 4'h1, 20'hA_5C30);
    chk("code b", dac[31:16], 64'hA5C3);
    chk("therm b", th[29:15], 64'h03FF);
    chk("ladder b", lad[23:12], 64'h05C3);
    i_qdac_host.send(64'h0003_10F0, 20);
    chk("short frame", dac, 64'h0000_0000_A5C3_0000);
    chk("short frame inp", inp, 64'h0000_0000_A5C3_0000);
    $display("test write done");
    wr(4'h0, 4'h2, 20'h1_2340);
    chk("input c", inp[47:32], 64'h1234);
    chk("held c", dac[47:32], 64'h0);
    pulse(1'b0);
    chk("loaded c", dac[47:32], 64'h1234);
    wr(4'h6, 4'h0, 20'h0_0008);
    chk("override", ovr, 64'h8);
    wr(4'h0, 4'h3, 20'hB_EEF0);
    chk("forced d", dac[63:48], 64'hBEEF);
    wr(4'h0, 4'h0, 20'h0_F0F0);
    chk("held a", dac[15:0], 64'h0);
    wr(4'h1, 4'h0, 20'h0);
    chk("update a", dac[15:0], 64'h0F0F);
    wr(4'h2, 4'h0, 20'h7_7770);
    chk("update all", dac, 64'hBEEF_1234_A5C3_7777);
    $display("test load done");
    for (int c = 9; c < 16; c++) begin
      wr(4'(c), 4'hF, 20'hF_FFFF);
    end
    wr(4'h3, 4'h5, 20'hF_FFFF);
    chk("reserved", dac, 64'hBEEF_1234_A5C3_7777);
    chk("reserved inp", inp, 64'hBEEF_1234_A5C3_7777);
    chk("reserved regs", {ce, cc, ovr, pm}, 64'h0800);
    wr(4'h4, 4'h0, 20'h0_0203);
    chk("power", pm, 64'h0A);
    wr(4'h3, 4'hF, 20'h4_3210);
    chk("all chans", dac, 64'h4321_4321_4321_4321);
    // Load held low through a plain input write updates at execution
    @(negedge mclk_i);
    ld_n = 1'b0;
    wr(4'h0, 4'h1, 20'h5_6780);
    ld_n = 1'b1;
    chk("load low b", dac[31:16], 64'h5678);
    i_qdac_host.send({24'h0, 32'h0306_6660, 8'hFF}, 40);
    chk("extra clocks", dac[15:0], 64'h6666);
    chk("extra ovr", ovr, 64'h8);
    $display("test command done");
    wr(4'h5, 4'h0, 20'h0_0001);
    chk("clear sel", cc, 64'h1);
    fork
      wr(4'h3, 4'h0, 20'h1_1110);
      begin
        #2000;
        pulse(1'b1);
      end
    join
    chk("clear dac", dac, 64'h8000_8000_8000_8000);
    chk("clear inp", inp, 64'h8000_8000_8000_8000);
    wr(4'h8, 4'h0, 20'h0_0002);
    chk("chain on", ce, 64'h1);
    // Two devices' worth; load pulsed once the burst is over
    i_qdac_host.send({32'h0312_2220, 32'h0003_3330}, 64);
    chk("chain exec", inp[31:0], 64'h8000_3333);
    chk("chain held", dac[15:0], 64'h8000);
    chk("chain out", i_qdac_host.rx[31:0], 64'h0312_2220);
    pulse(1'b0);
    chk("chain load", dac[31:0], 64'h8000_3333);
    // Eight bits too many: the last whole word must not run
    i_qdac_host.send(64'h0305_5550, 40);
    chk("chain odd", dac[15:0], 64'h3333);
    wr(4'h7, 4'h0, 20'h0);
    chk("soft reset", {ce, co, cc, ovr, pm}, 64'h0);
    chk("soft reset code", dac, 64'h0);
    $display("test chain done");
    report_and_stop();
  end
endmodule : qdac_port_tb
